//--- hw/i2cam_pkg.sv
// package for the address match and interrupt block
// shared constants: register offsets, field positions, reset values, timing
package i2cam_pkg;
  localparam int unsigned ADDR_W  = 6;
  localparam int unsigned DATA_W  = 16;
  localparam int unsigned OA_W    = 10;
  // register offsets
  localparam logic [5:0] OFF_CTRL      = 6'h00;
  localparam logic [5:0] OFF_STATUS    = 6'h08;
  localparam logic [5:0] OFF_TBCNT     = 6'h0A;
  localparam logic [5:0] OFF_RXBUF     = 6'h0C;
  localparam logic [5:0] OFF_TXBUF     = 6'h0E;
  localparam logic [5:0] OFF_OA0       = 6'h14;
  localparam logic [5:0] OFF_OA1       = 6'h16;
  localparam logic [5:0] OFF_OA2       = 6'h18;
  localparam logic [5:0] OFF_OA3       = 6'h1A;
  localparam logic [5:0] OFF_ADDRX     = 6'h1C;
  localparam logic [5:0] OFF_ADDMASK   = 6'h1E;
  localparam logic [5:0] OFF_IE        = 6'h2A;
  localparam logic [5:0] OFF_IFG       = 6'h2C;
  localparam logic [5:0] OFF_IV        = 6'h2E;
  // control register fields
  localparam int unsigned CTL_SWRST  = 0;
  localparam int unsigned CTL_STT    = 1;
  localparam int unsigned CTL_TXACK  = 5;
  localparam int unsigned CTL_MST    = 11;
  localparam int unsigned CTL_SWACK  = 12;
  localparam int unsigned CTL_ETXINT = 13;
  localparam int unsigned CTL_GIE    = 14;
  localparam int unsigned CTL_AST_LO = 2;
  localparam int unsigned CTL_CLTO_LO = 6;
  localparam int unsigned CTL_MM     = 8;
  // own address enable bit
  localparam int unsigned OA_EN      = 10;
  // flag register bit positions
  localparam int unsigned F_RX0   = 0;
  localparam int unsigned F_TX0   = 1;
  localparam int unsigned F_STT   = 2;
  localparam int unsigned F_STP   = 3;
  localparam int unsigned F_AL    = 4;
  localparam int unsigned F_NACK  = 5;
  localparam int unsigned F_BCNT  = 6;
  localparam int unsigned F_CLTO  = 7;
  localparam int unsigned F_BIT9  = 8;
  localparam int unsigned F_TX1   = 9;
  localparam int unsigned F_RX1   = 10;
  localparam int unsigned F_TX2   = 11;
  localparam int unsigned F_RX2   = 12;
  localparam int unsigned F_TX3   = 13;
  localparam int unsigned F_RX3   = 14;
  localparam int unsigned NFLAGS  = 15;
  // reset values
  localparam logic [15:0] RST_CTRL    = 16'h0001;
  localparam logic [15:0] RST_ADDMASK = 16'h03FF;
  localparam logic [15:0] RST_ZERO    = 16'h0000;
  // auto stop modes
  localparam logic [1:0] AST_BCNT = 2'b01;
  localparam logic [1:0] AST_STOP = 2'b10;
  // clock low timeout, in microseconds per selection step
  localparam int unsigned CLTO_US     = 25;
  localparam int unsigned CLK_MHZ     = 200;
  localparam int unsigned CLTO_CYCLES = CLTO_US * CLK_MHZ;
  typedef enum logic [1:0] {
    I2CAM_IDLE = 2'b00,
    I2CAM_ADDR = 2'b01,
    I2CAM_DATA = 2'b11,
    I2CAM_WAIT = 2'b10
  } i2cam_state_e;
endpackage

//--- hw/i2cam_top.sv
// address match, flags, enables and vector logic of a two-wire bus controller
// assumes a bit engine supplies bus events as one-cycle pulses on core_clk_i;
// bus clock level arrives asynchronously and is synchronised here
//
// The address-and-strobe port and the address map are this design's own decisions.
`timescale 1ns/1ps
module i2cam_top
  import i2cam_pkg::*;
#(
  parameter int unsigned CLTO_BASE = i2cam_pkg::CLTO_CYCLES
)(
  input  wire logic                          core_clk_i,
  input  wire logic                          rst_i,
  input  wire logic [i2cam_pkg::ADDR_W-1:0]  addr_i,
  input  wire logic [i2cam_pkg::DATA_W-1:0]  wdata_i,
  input  wire logic                          wr_i,
  input  wire logic                          rd_i,
  output logic      [i2cam_pkg::DATA_W-1:0]  rdata_o,
  input  wire logic                          bus_scl_i,
  input  wire logic                          ev_start_i,
  input  wire logic                          ev_stop_i,
  input  wire logic                          ev_addr_i,
  input  wire logic [i2cam_pkg::OA_W-1:0]    rx_addr_i,
  input  wire logic                          rx_addr_rw_i,
  input  wire logic                          ev_rx_byte_i,
  input  wire logic [7:0]                    rx_byte_i,
  input  wire logic                          ev_tx_ready_i,
  input  wire logic                          ev_byte_cnt_i,
  input  wire logic                          ev_ninth_i,
  input  wire logic                          ev_nack_i,
  input  wire logic                          ev_arb_lost_i,
  input  wire logic                          busy_i,
  input  wire logic                          low_power_i,
  output logic                               addr_ack_o,
  output logic                               tx_byte_valid_o,
  output logic      [7:0]                    tx_byte_o,
  output logic                               clk_req_o,
  output logic                               irq_o
);
  import i2cam_pkg::*;

  function automatic logic oa_hit(input logic [15:0] oa, input logic [9:0] a,
                                  input logic [9:0] m);
    oa_hit = oa[OA_EN] && (((oa[9:0] ^ a) & m) == 10'h000);
  endfunction

  logic [15:0] ctrl, next_ctrl;
  logic [15:0] tbcnt, next_tbcnt;
  logic [15:0] oa [4];
  logic [15:0] next_oa [4];
  logic [15:0] addmask, next_addmask;
  logic [15:0] ie, next_ie;
  logic [NFLAGS-1:0] ifg, next_ifg;
  logic [9:0]  addrx, next_addrx;
  logic [7:0]  rxbuf, next_rxbuf;
  logic [7:0]  txbuf, next_txbuf;
  logic [1:0]  match_idx, next_match_idx;
  logic [7:0]  bcnt, next_bcnt;
  logic [7:0]  tx0_cnt, next_tx0_cnt;
  logic [15:0] rdata, next_rdata;
  logic        ack, next_ack;
  logic        txv, next_txv;
  logic        creq, next_creq;
  logic        irq, next_irq;
  logic        scl_s1, scl_s2;
  logic [15:0] low_cnt, next_low_cnt;
  logic        clto_done, next_clto_done;
  i2cam_state_e state, next_state;

  logic [15:0] vec;
  logic [3:0]  vsel;
  logic        vhit;
  logic [15:0] pend;
  logic [15:0] clto_lim;

  // vector priority: flag order of codes 02..1E
  localparam int unsigned VORD [15] = '{F_AL, F_NACK, F_STT, F_STP, F_RX3, F_TX3,
    F_RX2, F_TX2, F_RX1, F_TX1, F_RX0, F_TX0, F_BCNT, F_CLTO, F_BIT9};

  always_comb
  begin
    pend = {1'b0, ifg & ie[NFLAGS-1:0]};
    vhit = 1'b0;
    vsel = 4'h0;
    vec  = 16'h0000;
    for (int i = 14; i >= 0; i--)
    begin
      if (pend[VORD[i]])
      begin
        vhit = 1'b1;
        vsel = 4'(VORD[i]);
        vec  = 16'((i + 1) * 2);
      end
    end
    clto_lim = 16'(CLTO_BASE) * {14'h0000, ctrl[CTL_CLTO_LO +: 2]};
  end

  always_comb
  begin
    logic [9:0] m;
    logic       sw_rst;
    logic       slave;
    logic       hit0;
    logic [3:0] hits;
    m = addmask[9:0];
    sw_rst = ctrl[CTL_SWRST];
    slave = !ctrl[CTL_MST];
    hit0 = 1'b0;
    hits = 4'h0;
    next_ctrl = ctrl;
    next_tbcnt = tbcnt;
    next_oa = oa;
    next_addmask = addmask;
    next_ie = ie;
    next_ifg = ifg;
    next_addrx = addrx;
    next_rxbuf = rxbuf;
    next_txbuf = txbuf;
    next_match_idx = match_idx;
    next_bcnt = bcnt;
    next_tx0_cnt = tx0_cnt;
    next_rdata = 16'h0000;
    next_ack = 1'b0;
    next_txv = 1'b0;
    next_state = state;
    next_low_cnt = 16'h0000;
    next_clto_done = clto_done;
    // software side: clears first so hardware sets below win
    if (wr_i)
    begin
      case (addr_i)
        OFF_CTRL:    next_ctrl = wdata_i;
        OFF_TBCNT:   next_tbcnt = wdata_i;
        OFF_TXBUF:
        begin
          next_txbuf = wdata_i[7:0];
          next_txv = 1'b1;
          next_ifg[F_TX0] = 1'b0;
          next_ifg[F_TX1] = 1'b0;
          next_ifg[F_TX2] = 1'b0;
          next_ifg[F_TX3] = 1'b0;
        end
        OFF_OA0:     next_oa[0] = wdata_i;
        OFF_OA1:     next_oa[1] = wdata_i;
        OFF_OA2:     next_oa[2] = wdata_i;
        OFF_OA3:     next_oa[3] = wdata_i;
        OFF_ADDMASK: next_addmask = wdata_i;
        OFF_IE:      next_ie = wdata_i;
        OFF_IFG:
        begin
          next_ifg = wdata_i[NFLAGS-1:0];
          if (ifg[F_AL] && !wdata_i[F_AL])
            next_ifg = next_ifg & ~(NFLAGS'(1) << F_TX0 | NFLAGS'(1) << F_TX1
              | NFLAGS'(1) << F_TX2 | NFLAGS'(1) << F_TX3);
        end
        OFF_IV:      next_ifg = '0;
        default:     next_ifg = next_ifg;
      endcase
    end
    if (rd_i)
    begin
      case (addr_i)
        OFF_CTRL:    next_rdata = ctrl;
        OFF_STATUS:  next_rdata = {7'h00, busy_i, bcnt};
        OFF_TBCNT:   next_rdata = tbcnt;
        OFF_RXBUF:
        begin
          next_rdata = {8'h00, rxbuf};
          next_ifg[F_RX0] = 1'b0;
          next_ifg[F_RX1] = 1'b0;
          next_ifg[F_RX2] = 1'b0;
          next_ifg[F_RX3] = 1'b0;
        end
        OFF_TXBUF:   next_rdata = {8'h00, txbuf};
        OFF_OA0:     next_rdata = oa[0];
        OFF_OA1:     next_rdata = oa[1];
        OFF_OA2:     next_rdata = oa[2];
        OFF_OA3:     next_rdata = oa[3];
        OFF_ADDRX:   next_rdata = {6'h00, addrx};
        OFF_ADDMASK: next_rdata = addmask;
        OFF_IE:      next_rdata = ie;
        OFF_IFG:     next_rdata = {1'b0, ifg};
        OFF_IV:
        begin
          next_rdata = vec;
          if (vhit)
            next_ifg[vsel] = 1'b0;
        end
        default:     next_rdata = 16'h0000;
      endcase
    end
    // address compare
    if (slave || ctrl[CTL_MM])
      hit0 = (m != 10'h3FF) ? oa_hit(oa[0], rx_addr_i, m)
                            : oa_hit(oa[0], rx_addr_i, 10'h3FF);
    hits = {oa_hit(oa[3], rx_addr_i, 10'h3FF), oa_hit(oa[2], rx_addr_i, 10'h3FF),
            oa_hit(oa[1], rx_addr_i, 10'h3FF), hit0};
    case (state)
      I2CAM_IDLE:
        if (ev_start_i)
          next_state = I2CAM_ADDR;
      I2CAM_ADDR:
        if (ev_addr_i && hits != 4'h0)
        begin
          next_addrx = rx_addr_i;
          next_match_idx = hits[3] ? 2'd3 : hits[2] ? 2'd2 : hits[1] ? 2'd1 : 2'd0;
          if (slave)
            next_ifg[F_STT] = 1'b1;
          if (hits[3:1] != 3'h0 || !ctrl[CTL_SWACK])
          begin
            next_ack = 1'b1;
            next_state = I2CAM_DATA;
          end
          else
            next_state = I2CAM_WAIT;
          if (slave && rx_addr_rw_i && !ctrl[CTL_ETXINT])
          begin
            case (next_match_idx)
              2'd3:    next_ifg[F_TX3] = 1'b1;
              2'd2:    next_ifg[F_TX2] = 1'b1;
              2'd1:    next_ifg[F_TX1] = 1'b1;
              default: next_ifg[F_TX0] = 1'b1;
            endcase
          end
        end
        else if (ev_addr_i)
          next_state = I2CAM_IDLE;
      I2CAM_WAIT:
        if (wr_i && addr_i == OFF_CTRL && wdata_i[CTL_TXACK])
        begin
          next_ack = 1'b1;
          next_ctrl[CTL_TXACK] = 1'b0;
          next_state = I2CAM_DATA;
        end
      I2CAM_DATA:
        if (ev_start_i)
          next_state = I2CAM_ADDR;
      default:
        next_state = I2CAM_IDLE;
    endcase
    if (ev_stop_i)
    begin
      next_state = I2CAM_IDLE;
      next_ifg[F_STP] = 1'b1;
    end
    if (ev_start_i)
    begin
      next_bcnt = 8'h00;
      next_tx0_cnt = 8'h00;
      if (slave && ctrl[CTL_ETXINT])
        next_ifg[F_TX0] = 1'b1;
    end
    if (wr_i && addr_i == OFF_CTRL && wdata_i[CTL_STT] && wdata_i[CTL_MST])
      next_ifg[F_TX0] = 1'b1;
    if (ev_tx_ready_i)
    begin
      if (!slave && ctrl[CTL_AST_LO +: 2] == AST_STOP)
      begin
        if (tx0_cnt < tbcnt[7:0])
        begin
          next_ifg[F_TX0] = 1'b1;
          next_tx0_cnt = tx0_cnt + 8'h01;
        end
      end
      else
        case (match_idx)
          2'd3:    next_ifg[F_TX3] = 1'b1;
          2'd2:    next_ifg[F_TX2] = 1'b1;
          2'd1:    next_ifg[F_TX1] = 1'b1;
          default: next_ifg[F_TX0] = 1'b1;
        endcase
    end
    if (ev_rx_byte_i)
    begin
      next_rxbuf = rx_byte_i;
      case (match_idx)
        2'd3:    next_ifg[F_RX3] = 1'b1;
        2'd2:    next_ifg[F_RX2] = 1'b1;
        2'd1:    next_ifg[F_RX1] = 1'b1;
        default: next_ifg[F_RX0] = 1'b1;
      endcase
    end
    if (ev_byte_cnt_i)
    begin
      next_bcnt = bcnt + 8'h01;
      if (tbcnt[7:0] != 8'h00 && bcnt + 8'h01 == tbcnt[7:0]
          && (ctrl[CTL_AST_LO +: 2] == AST_BCNT || ctrl[CTL_AST_LO +: 2] == AST_STOP))
        next_ifg[F_BCNT] = 1'b1;
    end
    if (ev_ninth_i && state == I2CAM_DATA)
      next_ifg[F_BIT9] = 1'b1;
    if (ev_nack_i && !slave)
      next_ifg[F_NACK] = 1'b1;
    if (ev_arb_lost_i)
    begin
      next_ifg[F_AL] = 1'b1;
      next_ctrl[CTL_MST] = 1'b0;
    end
    // clock low timeout, once per low period
    if (!scl_s2 && busy_i && clto_lim != 16'h0000)
    begin
      next_low_cnt = (low_cnt == 16'hFFFF) ? low_cnt : low_cnt + 16'h0001;
      if (low_cnt == clto_lim && !clto_done)
      begin
        next_ifg[F_CLTO] = 1'b1;
        next_clto_done = 1'b1;
      end
    end
    else
      next_clto_done = 1'b0;
    if (sw_rst)
    begin
      next_ie[F_RX0] = 1'b0;
      next_ie[F_TX0] = 1'b0;
      next_ie[F_TX1] = 1'b0;
      next_ie[F_RX1] = 1'b0;
      next_ie[F_TX2] = 1'b0;
      next_ie[F_RX2] = 1'b0;
      next_ie[F_TX3] = 1'b0;
      next_ie[F_RX3] = 1'b0;
      next_ifg[F_RX0] = 1'b0;
      next_ifg[F_RX1] = 1'b0;
      next_ifg[F_RX2] = 1'b0;
      next_ifg[F_RX3] = 1'b0;
      next_state = I2CAM_IDLE;
    end
    next_creq = low_power_i && busy_i && !slave;
    next_irq = ctrl[CTL_GIE] && ((next_ifg & next_ie[NFLAGS-1:0]) != '0);
  end

  always_ff @(posedge core_clk_i)
  begin
    scl_s1 <= bus_scl_i;
    scl_s2 <= scl_s1;
    if (rst_i)
    begin
      ctrl <= RST_CTRL;
      tbcnt <= RST_ZERO;
      oa <= '{RST_ZERO, RST_ZERO, RST_ZERO, RST_ZERO};
      addmask <= RST_ADDMASK;
      ie <= RST_ZERO;
      ifg <= '0;
      addrx <= 10'h000;
      rxbuf <= 8'h00;
      txbuf <= 8'h00;
      match_idx <= 2'd0;
      bcnt <= 8'h00;
      tx0_cnt <= 8'h00;
      rdata <= RST_ZERO;
      ack <= 1'b0;
      txv <= 1'b0;
      creq <= 1'b0;
      irq <= 1'b0;
      low_cnt <= 16'h0000;
      clto_done <= 1'b0;
      state <= I2CAM_IDLE;
    end
    else
    begin
      ctrl <= next_ctrl;
      tbcnt <= next_tbcnt;
      oa <= next_oa;
      addmask <= next_addmask;
      ie <= next_ie;
      ifg <= next_ifg;
      addrx <= next_addrx;
      rxbuf <= next_rxbuf;
      txbuf <= next_txbuf;
      match_idx <= next_match_idx;
      bcnt <= next_bcnt;
      tx0_cnt <= next_tx0_cnt;
      rdata <= next_rdata;
      ack <= next_ack;
      txv <= next_txv;
      creq <= next_creq;
      irq <= next_irq;
      low_cnt <= next_low_cnt;
      clto_done <= next_clto_done;
      state <= next_state;
    end
  end

  assign rdata_o = rdata;
  assign addr_ack_o = ack;
  assign tx_byte_valid_o = txv;
  assign tx_byte_o = txbuf;
  assign clk_req_o = creq;
  assign irq_o = irq;
endmodule

//--- test/i2cam_assertions.sv
// checker for the address match and interrupt block
// sees only the top ports; bound into every i2cam_top
`timescale 1ns/1ps
module i2cam_checker
  import i2cam_pkg::*;
(
  input wire logic                         core_clk_i,
  input wire logic                         rst_i,
  input wire logic [i2cam_pkg::ADDR_W-1:0] addr_i,
  input wire logic [i2cam_pkg::DATA_W-1:0] wdata_i,
  input wire logic                         wr_i,
  input wire logic                         rd_i,
  input wire logic [i2cam_pkg::DATA_W-1:0] rdata_o,
  input wire logic                         ev_start_i,
  input wire logic                         ev_stop_i,
  input wire logic                         ev_addr_i,
  input wire logic                         ev_rx_byte_i,
  input wire logic                         ev_tx_ready_i,
  input wire logic                         ev_byte_cnt_i,
  input wire logic                         ev_ninth_i,
  input wire logic                         ev_nack_i,
  input wire logic                         ev_arb_lost_i,
  input wire logic                         busy_i,
  input wire logic                         addr_ack_o,
  input wire logic                         tx_byte_valid_o,
  input wire logic [7:0]                   tx_byte_o,
  input wire logic                         clk_req_o,
  input wire logic                         irq_o
);
  logic        global_irq_enable;
  logic        next_gie;
  logic [15:0] ie;
  logic [15:0] next_ie;
  logic        ev_any;
  assign ev_any = ev_start_i | ev_stop_i | ev_addr_i | ev_rx_byte_i | ev_tx_ready_i
                | ev_byte_cnt_i | ev_ninth_i | ev_nack_i | ev_arb_lost_i;
  // shadows of global enable and enables
  always_comb
  begin
    next_gie = global_irq_enable;
    next_ie  = ie;
    if (wr_i && addr_i == OFF_CTRL)
      next_gie = wdata_i[CTL_GIE];
    if (wr_i && addr_i == OFF_IE)
      next_ie = wdata_i;
  end
  always_ff @(posedge core_clk_i)
  begin
    global_irq_enable <= rst_i ? 1'b0 : next_gie;
    ie  <= rst_i ? 16'h0000 : next_ie;
  end
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  ack_cause_a: assert property (addr_ack_o |-> $past(ev_addr_i) ||
    $past(wr_i && addr_i == OFF_CTRL && wdata_i[CTL_TXACK])) else $error("ack without cause");
  txb_cause_a: assert property (tx_byte_valid_o |-> $past(wr_i && addr_i == OFF_TXBUF)
    && tx_byte_o == $past(wdata_i[7:0])) else $error("tx byte without write");
  clk_idle_a: assert property (!$past(busy_i) && !$past(busy_i, 2) |-> !clk_req_o)
    else $error("clock request while idle");
  irq_gie_a: assert property (!global_irq_enable && !$past(global_irq_enable) |-> !irq_o)
    else $error("irq with global enable off");
  irq_ie_a: assert property (ie == 16'h0000 && $past(ie) == 16'h0000 |-> !irq_o)
    else $error("irq with no enable");
  iv_code_a: assert property ($past(rd_i && addr_i == OFF_IV) |->
    !rdata_o[0] && rdata_o <= 16'h001E) else $error("bad vector code");
  iv_masked_a: assert property ($past(rd_i && addr_i == OFF_IV && ie == 16'h0000) |->
    rdata_o == 16'h0000) else $error("vector from disabled flag");
  iv_wrclr_a: assert property ($past(wr_i && addr_i == OFF_IV && !ev_any, 3) &&
    !$past(ev_any, 2) &&
    $past(rd_i && addr_i == OFF_IFG) |-> rdata_o == 16'h0000) else $error("flags after clear");
endmodule
bind i2cam_top i2cam_checker i_chk (.*);

//--- test/i2cam_bus_model.sv
// far side: bit engine events and other bus parties
// scl runs only inside frames, idles high (pull-up)
`timescale 1ns/1ps
module i2cam_bus_model (
  input  wire logic       clk_i,
  output logic            scl_o,
  output logic [8:0]      ev_o,
  output logic [9:0]      addr_o,
  output logic            rw_o,
  output logic [7:0]      byte_o
);
  logic run = 1'b0;
  logic hold = 1'b0;
  initial
  begin
    scl_o = 1'b1;
    ev_o = '0;
    addr_o = '0;
    rw_o = 1'b0;
    byte_o = '0;
  end
  always #40 scl_o = hold ? 1'b0 : (run ? ~scl_o : 1'b1);
  task automatic pulse(input int i);
    @(posedge clk_i);
    ev_o[i] <= 1'b1;
    @(posedge clk_i);
    ev_o[i] <= 1'b0;
  endtask
  // start, then the address in the very next cycle
  task automatic frame(input logic [9:0] a, input logic r);
    run = 1'b1;
    pulse(0);
    ev_o[2] <= 1'b1;
    addr_o <= a;
    rw_o <= r;
    @(posedge clk_i);
    ev_o[2] <= 1'b0;
    addr_o <= ~a;
    rw_o <= ~r;
  endtask
  task automatic rxb(input logic [7:0] b);
    @(posedge clk_i);
    ev_o[3] <= 1'b1;
    byte_o <= b;
    @(posedge clk_i);
    ev_o[3] <= 1'b0;
    byte_o <= ~b;
  endtask
  task automatic stop();
    pulse(1);
    run = 1'b0;
  endtask
  task automatic low(input int n);
    hold = 1'b1;
    repeat (n) @(posedge clk_i);
    hold = 1'b0;
  endtask
endmodule

//--- test/i2cam_top_test.sv
// testbench for the address match and interrupt block
// bus model drives events; register port driven here
`timescale 1ns/1ps
module i2cam_top_test
  import i2cam_pkg::*;
;
  logic core_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [5:0] addr_i = '0;
  logic [15:0] wdata_i = '0;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic busy_i = 1'b0;
  logic low_power_i = 1'b0;
  logic [15:0] rdata_o;
  logic scl;
  logic [8:0] ev;
  logic [9:0] ra;
  logic rw;
  logic [7:0] rb;
  logic addr_ack_o, tx_byte_valid_o, clk_req_o, irq_o;
  logic [7:0] tx_byte_o;
  logic [7:0] last_tx = '0;
  int acks = 0;
  int num_errors = 0;
  int checks_done = 0;
  initial
  begin
    forever #2.5 core_clk_i = ~core_clk_i;
  end
  i2cam_bus_model i_i2cam_bus_model (.clk_i(core_clk_i), .scl_o(scl), .ev_o(ev),
    .addr_o(ra), .rw_o(rw), .byte_o(rb));
  i2cam_top #(.CLTO_BASE(20)) i_i2cam_top (.core_clk_i(core_clk_i), .rst_i(rst_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .bus_scl_i(scl), .ev_start_i(ev[0]), .ev_stop_i(ev[1]), .ev_addr_i(ev[2]),
    .rx_addr_i(ra), .rx_addr_rw_i(rw), .ev_rx_byte_i(ev[3]), .rx_byte_i(rb),
    .ev_tx_ready_i(ev[4]), .ev_byte_cnt_i(ev[5]), .ev_ninth_i(ev[6]), .ev_nack_i(ev[7]),
    .ev_arb_lost_i(ev[8]), .busy_i(busy_i), .low_power_i(low_power_i),
    .addr_ack_o(addr_ack_o), .tx_byte_valid_o(tx_byte_valid_o), .tx_byte_o(tx_byte_o),
    .clk_req_o(clk_req_o), .irq_o(irq_o));
  always @(posedge core_clk_i)
  begin
    if (addr_ack_o)
      acks <= acks + 1;
    if (tx_byte_valid_o)
      last_tx <= tx_byte_o;
  end
  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    checks_done++;
    if (s !== e)
    begin
      num_errors++;
      $display("wrong value at %0t: got %h want %h", $time, s, e);
    end
  endtask
  task automatic wr(input logic [5:0] a, input logic [15:0] d);
    @(posedge core_clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge core_clk_i);
    wr_i <= 1'b0;
  endtask
  task automatic rdc(input logic [5:0] a, input logic [15:0] e);
    @(posedge core_clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge core_clk_i);
    rd_i <= 1'b0;
    #1 chk(rdata_o, e);
  endtask
  task automatic t_match();
    int n;
    n = acks;
    wr(OFF_OA0, 16'h045A);
    wr(OFF_ADDMASK, 16'h03F0);
    wr(OFF_IE, 16'h7FFF);
    i_i2cam_bus_model.frame(10'h05F, 1'b0);
    repeat (2) @(posedge core_clk_i);
    chk(16'(acks - n), 16'h0001);
    i_i2cam_bus_model.frame(10'h0AF, 1'b0);
    repeat (2) @(posedge core_clk_i);
    chk(16'(acks - n), 16'h0001);
    i_i2cam_bus_model.stop();
    i_i2cam_bus_model.pulse(7);
    rdc(OFF_IFG, 16'h000C);
    chk({15'h0000, irq_o}, 16'h0001);
    rdc(OFF_IV, 16'h0006);
    rdc(OFF_IV, 16'h0008);
    rdc(OFF_IV, 16'h0000);
  endtask
  task automatic t_prio();
    wr(OFF_CTRL, 16'h4904);
    wr(OFF_TBCNT, 16'h0001);
    i_i2cam_bus_model.frame(10'h05A, 1'b0);
    i_i2cam_bus_model.pulse(5);
    i_i2cam_bus_model.pulse(6);
    i_i2cam_bus_model.pulse(7);
    i_i2cam_bus_model.pulse(8);
    rdc(OFF_IFG, 16'h0170);
    rdc(OFF_CTRL, 16'h4104);
    wr(OFF_IE, 16'h0100);
    rdc(OFF_IV, 16'h001E);
    wr(OFF_IE, 16'h7FFF);
    rdc(OFF_IV, 16'h0002);
    rdc(OFF_IV, 16'h0004);
    rdc(OFF_IFG, 16'h0040);
    wr(OFF_IV, 16'h0000);
    rdc(OFF_IFG, 16'h0000);
  endtask
  task automatic t_rx();
    wr(OFF_OA1, 16'h0433);
    wr(OFF_OA3, 16'h0433);
    i_i2cam_bus_model.frame(10'h033, 1'b0);
    wr(OFF_IV, 16'h0000);
    i_i2cam_bus_model.rxb(8'h3C);
    rdc(OFF_IFG, 16'h4000);
    rdc(OFF_RXBUF, 16'h003C);
    rdc(OFF_IFG, 16'h0000);
    i_i2cam_bus_model.rxb(8'hC3);
    wr(OFF_CTRL, 16'h4001);
    rdc(OFF_IE, 16'h01FC);
    rdc(OFF_IFG, 16'h0000);
    wr(OFF_CTRL, 16'h4000);
    wr(OFF_OA1, 16'h0000);
    wr(OFF_OA3, 16'h0000);
  endtask
  task automatic t_tx();
    i_i2cam_bus_model.frame(10'h05A, 1'b1);
    rdc(OFF_IFG, 16'h0006);
    wr(OFF_TXBUF, 16'h00A5);
    rdc(OFF_IFG, 16'h0004);
    chk({8'h00, last_tx}, 16'h00A5);
    i_i2cam_bus_model.pulse(4);
    rdc(OFF_IFG, 16'h0006);
    i_i2cam_bus_model.stop();
    wr(OFF_IV, 16'h0000);
    wr(OFF_CTRL, 16'h4802);
    rdc(OFF_IFG, 16'h0002);
    wr(OFF_CTRL, 16'h6000);
    wr(OFF_IV, 16'h0000);
    i_i2cam_bus_model.pulse(0);
    rdc(OFF_IFG, 16'h0002);
  endtask
  task automatic t_swack();
    int n;
    wr(OFF_CTRL, 16'h5000);
    n = acks;
    i_i2cam_bus_model.frame(10'h05A, 1'b0);
    repeat (4) @(posedge core_clk_i);
    chk(16'(acks - n), 16'h0000);
    wr(OFF_CTRL, 16'h5020);
    repeat (2) @(posedge core_clk_i);
    chk(16'(acks - n), 16'h0001);
    i_i2cam_bus_model.stop();
    wr(OFF_IV, 16'h0000);
    wr(OFF_CTRL, 16'h4808);
    i_i2cam_bus_model.pulse(4);
    rdc(OFF_IFG, 16'h0002);
    wr(OFF_IV, 16'h0000);
    i_i2cam_bus_model.pulse(4);
    rdc(OFF_IFG, 16'h0000);
  endtask
  task automatic t_clto();
    wr(OFF_CTRL, 16'h4040);
    wr(OFF_IV, 16'h0000);
    busy_i <= 1'b1;
    low_power_i <= 1'b1;
    i_i2cam_bus_model.low(8);
    repeat (30) @(posedge core_clk_i);
    rdc(OFF_IFG, 16'h0000);
    i_i2cam_bus_model.low(100);
    repeat (30) @(posedge core_clk_i);
    rdc(OFF_IFG, 16'h0080);
    wr(OFF_CTRL, 16'h4840);
    repeat (2) @(posedge core_clk_i);
    chk({15'h0000, clk_req_o}, 16'h0001);
    busy_i <= 1'b0;
    repeat (3) @(posedge core_clk_i);
    chk({15'h0000, clk_req_o}, 16'h0000);
  endtask
  task automatic finish_test();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial
  begin
    #50000;
    num_errors++;
    finish_test();
  end
  initial
  begin
    repeat (3) @(posedge core_clk_i);
    rst_i <= 1'b0;
    rdc(OFF_CTRL, RST_CTRL);
    rdc(OFF_ADDMASK, RST_ADDMASK);
    rdc(6'h3E, 16'h0000);
    wr(OFF_CTRL, 16'h4000);
    t_match();
    t_prio();
    t_rx();
    t_tx();
    t_swack();
    t_clto();
    finish_test();
  end
endmodule
